// [src/nand_host.sv]
`default_nettype none
`include "nand_host_cfg.svh"
module nand_host
    import nand_host_pkg::*;
#(
    parameter int RST_WAIT_CYC = ((`T_RST_MAX_US * `NS_PER_US) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int BUSY_TIMEOUT_CYC = (`T_R_MULTI_US * `NS_PER_US) / `CLK_PERIOD_NS * 2
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_op_valid,
    input wire op_kind_t i_op_kind,
    input wire logic [7:0] i_op_data,
    input wire logic i_op_last,
    input wire logic i_op_expect_busy,
    input wire logic i_op_release,
    input wire logic i_wp_enable,
    input wire logic [7:0] i_io_in,
    input wire logic i_ready_busy_n,
    output logic o_op_ready,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    output logic o_timeout,
    output logic o_cs_n,
    output logic o_cle,
    output logic o_ale,
    output logic o_write_strobe_n,
    output logic o_read_strobe_n,
    output logic o_write_protect_n,
    output logic [7:0] o_io_out,
    output logic o_io_oe
);
    localparam int WP_CYC = (`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int WH_CYC = (`T_WH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1;
    localparam int RP_CYC = (`T_REA_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1;
    localparam int REH_CYC = (`T_RHW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int WB_CYC = (`T_WB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1;
    localparam int WHR_CYC = (`T_WHR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    if (RST_WAIT_CYC < 1 || BUSY_TIMEOUT_CYC < WB_CYC + 1 || WHR_CYC > 255) begin : g_bad_timing
        $error("nand_host: unusable timing parameters");
    end
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_STROBE,
        ST_WAIT_WB,
        ST_WAIT_RDY,
        ST_GAP
    } state_t;
    state_t st_q, st_d;
    nand_strobe_if sif();
    nand_strobe_gen u_gen (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .s(sif)
    );
    // Three-stage sampling of the open-drain ready line; only agreeing late stages count.
    logic [2:0] rb_sync_q;
    logic rb_q;
    logic [7:0] rd_sync1_q;
    logic [7:0] rd_sync2_q;
    op_kind_t kind_q;
    logic last_q, busy_exp_q;
    logic [7:0] data_q;
    logic [31:0] wait_q;
    logic [31:0] wait_d;
    logic cs_n_q, cle_q, ale_q, we_n_q, re_n_q, wp_n_q, oe_q, op_rdy_q, rdv_q, to_q;
    logic [7:0] io_q, rdd_q;
    logic ecc_pending_q;
    logic [3:0] ecc_left_q;
    wire logic rb_next = (rb_sync_q[2] == rb_sync_q[1]) ? rb_sync_q[1] : rb_q;
    wire logic accept = (st_q == ST_IDLE) && i_op_valid && op_rdy_q;
    wire logic is_rd = (i_op_kind == OP_READ);
    // The bus is not driven for a read, while the device may be driving; the bus is never turned both ways.
    wire logic drive_now = accept && !is_rd;
    wire logic ecc_cmd = accept && (i_op_kind == OP_CMD) && (i_op_data == `CMD_ECC_STATUS);
    wire logic strobe_lo = sif.busy && !sif.phase_hi;
    wire logic wait_zero = (wait_q == 32'h0);
    wire logic rst_cmd = (kind_q == OP_CMD) && (data_q == `CMD_RESET);
    wire logic rd_cap = (st_q == ST_STROBE) && (kind_q == OP_READ) && sif.phase_hi && !re_n_q;
    assign sif.start = accept;
    assign sif.is_read = is_rd;
    assign sif.cnt_lo = is_rd ? 8'(RP_CYC) : 8'(WP_CYC);
    assign sif.cnt_hi = is_rd ? 8'(REH_CYC) : ((i_op_kind == OP_CMD) ? 8'(WHR_CYC) : 8'(WH_CYC));
    always_comb begin
        st_d = st_q;
        wait_d = wait_zero ? 32'h0 : wait_q - 32'h1;
        unique case (st_q)
            ST_IDLE: if (accept) st_d = ST_STROBE;
            ST_STROBE: if (sif.done) begin
                if (busy_exp_q) begin
                    st_d = ST_WAIT_WB;
                    wait_d = 32'(WB_CYC);
                end else begin
                    st_d = ST_IDLE;
                end
            end
            ST_WAIT_WB: if (wait_zero) begin
                st_d = ST_WAIT_RDY;
                // A reset command gets its own bound, since its length depends on what it interrupts.
                wait_d = rst_cmd ? 32'(RST_WAIT_CYC) : 32'(BUSY_TIMEOUT_CYC);
            end
            // Strobes stay high while busy; the host does not poll with commands here.
            ST_WAIT_RDY: if (rb_q || wait_zero) begin
                st_d = ST_GAP;
                wait_d = 32'(WHR_CYC);
            end
            ST_GAP: if (wait_zero) st_d = ST_IDLE;
        endcase
    end
    always_ff @(posedge i_mclk) begin
        rb_sync_q <= {rb_sync_q[1:0], i_ready_busy_n};
        rd_sync1_q <= i_io_in;
        rd_sync2_q <= rd_sync1_q;
        if (i_rst) begin
            st_q <= ST_IDLE;
            rb_q <= 1'b0;
            wait_q <= 32'h0;
            kind_q <= OP_CMD;
            last_q <= 1'b1;
            busy_exp_q <= 1'b0;
            data_q <= 8'h00;
        end else begin
            st_q <= st_d;
            rb_q <= rb_next;
            wait_q <= wait_d;
            if (accept) begin
                kind_q <= i_op_kind;
                last_q <= i_op_last;
                busy_exp_q <= i_op_expect_busy;
                data_q <= i_op_data;
            end
        end
    end
    // Pin drive. Latch enables are set on accept, a cycle before the strobe falls, and dropped in the wait after the strobe or with release requests.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cs_n_q <= 1'b1;
            cle_q <= 1'b0;
            ale_q <= 1'b0;
            we_n_q <= 1'b1;
            re_n_q <= 1'b1;
            oe_q <= 1'b0;
            io_q <= 8'h00;
        end else begin
            if (accept) begin
                cs_n_q <= 1'b0;
                cle_q <= (i_op_kind == OP_CMD);
                ale_q <= (i_op_kind == OP_ADDR);
                oe_q <= drive_now;
                if (drive_now) io_q <= i_op_data;
            end else if (st_q == ST_IDLE && i_op_release) begin
                // Select high only between operations; the ready line is not checked, and a timed-out wait also ends here.
                cs_n_q <= 1'b1;
                cle_q <= 1'b0;
                ale_q <= 1'b0;
                oe_q <= 1'b0;
            end else if (st_q == ST_WAIT_WB) begin
                cle_q <= 1'b0;
                ale_q <= 1'b0;
                oe_q <= 1'b0;
            end
            we_n_q <= !(strobe_lo && kind_q != OP_READ && st_q == ST_STROBE);
            // The byte is taken as the strobe rises, from a sample made after access time.
            re_n_q <= !(strobe_lo && kind_q == OP_READ && st_q == ST_STROBE);
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wp_n_q <= 1'b0;
            op_rdy_q <= 1'b0;
            rdv_q <= 1'b0;
            rdd_q <= 8'h00;
            to_q <= 1'b0;
            ecc_pending_q <= 1'b0;
            ecc_left_q <= 4'h0;
        end else begin
            // Write protect low keeps program and erase locked.
            wp_n_q <= i_wp_enable;
            op_rdy_q <= (st_d == ST_IDLE) && !accept;
            // Sampling before the strobe rises keeps the byte valid even when the device floats the bus.
            rdv_q <= rd_cap;
            if (rd_cap) begin
                rdd_q <= rd_sync2_q;
            end
            to_q <= (st_q == ST_WAIT_RDY) && wait_zero && !rb_q;
            // Count the sector entries still owed after an ECC status command.
            if (ecc_cmd) begin
                ecc_pending_q <= 1'b1;
                ecc_left_q <= 4'(`ECC_SECTORS);
            end else if (ecc_pending_q && sif.done && kind_q == OP_READ) begin
                ecc_left_q <= ecc_left_q - 4'h1;
                ecc_pending_q <= (ecc_left_q != 4'h1);
            end
        end
    end
    assign o_cs_n = cs_n_q;
    assign o_cle = cle_q;
    assign o_ale = ale_q;
    assign o_write_strobe_n = we_n_q;
    assign o_read_strobe_n = re_n_q;
    assign o_write_protect_n = wp_n_q;
    assign o_io_out = io_q;
    assign o_io_oe = oe_q;
    assign o_op_ready = op_rdy_q;
    assign o_rd_valid = rdv_q;
    assign o_rd_data = rdd_q;
    assign o_timeout = to_q;
    // Waits for ready after busy-expecting ops bound reset/read/program.
    property p_no_drive_on_read;
        @(posedge i_mclk) disable iff (i_rst) !re_n_q |-> !oe_q;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus driven during read");
    property p_strobes_excl;
        @(posedge i_mclk) disable iff (i_rst) !(!we_n_q && !re_n_q);
    endproperty
    a_strobes_excl: assert property (p_strobes_excl) else $error("both strobes low");
    property p_busy_strobes_high;
        @(posedge i_mclk) disable iff (i_rst) (st_q == ST_WAIT_RDY) |-> (we_n_q && re_n_q);
    endproperty
    a_busy_strobes_high: assert property (p_busy_strobes_high) else $error("strobe moved while busy");
    property p_cs_hold_busy;
        @(posedge i_mclk) disable iff (i_rst) (st_q == ST_WAIT_RDY) |-> !cs_n_q;
    endproperty
    a_cs_hold_busy: assert property (p_cs_hold_busy) else $error("select released while busy");
    property p_cle_ale_excl;
        @(posedge i_mclk) disable iff (i_rst) !(cle_q && ale_q);
    endproperty
    a_cle_ale_excl: assert property (p_cle_ale_excl) else $error("both latches high");
    property p_wp_follow;
        @(posedge i_mclk) disable iff (i_rst) !i_wp_enable |=> !wp_n_q;
    endproperty
    a_wp_follow: assert property (p_wp_follow) else $error("write protect not applied");
    property p_we_width;
        @(posedge i_mclk) disable iff (i_rst) $fell(we_n_q) |-> !we_n_q [*2];
    endproperty
    a_we_width: assert property (p_we_width) else $error("write pulse too short");
    property p_re_width;
        @(posedge i_mclk) disable iff (i_rst) $fell(re_n_q) |-> !re_n_q [*3];
    endproperty
    a_re_width: assert property (p_re_width) else $error("read pulse too short");
    property p_ecc_all_read;
        @(posedge i_mclk) disable iff (i_rst) $rose(cle_q) |-> !$past(ecc_pending_q);
    endproperty
    a_ecc_all_read: assert property (p_ecc_all_read) else $error("command before sector entries read");
    c_cmd: cover property (@(posedge i_mclk) $rose(cle_q));
    c_read: cover property (@(posedge i_mclk) $fell(re_n_q));
    c_busy: cover property (@(posedge i_mclk) st_q == ST_WAIT_RDY ##1 st_q == ST_GAP);
endmodule : nand_host
`default_nettype wire

// [src/nand_host_cfg.svh]
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH
`define CLK_PERIOD_NS 8
`define T_WP_NS 12
`define T_WH_NS 10
`define T_RP_NS 12
`define T_REH_NS 10
`define T_REA_NS 20
`define T_WB_NS 100
`define T_WHR_NS 60
`define T_RHW_NS 30
`define T_RST_MAX_US 500
`define T_R_MULTI_US 420
`define T_PROG_US 700
`define NS_PER_US 1000
`define CMD_ECC_STATUS 8'h7a
`define CMD_RESET 8'hff
`define ECC_SECTORS 8
`define MAX_PARTIAL_PROG 4
`endif

// [src/nand_host_pkg.sv]
`default_nettype none
package nand_host_pkg;
    typedef enum logic [1:0] {
        OP_CMD,
        OP_ADDR,
        OP_WRITE,
        OP_READ
    } op_kind_t;
    typedef enum logic {
        HOLD_NORMAL,
        HOLD_EXTENDED
    } hold_mode_t;
endpackage : nand_host_pkg
`default_nettype wire

// [src/nand_strobe_if.sv]
`default_nettype none
interface nand_strobe_if;
    logic start;
    logic is_read;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic busy;
    logic phase_hi;
    logic done;
    modport ctl(output start, output is_read, output cnt_lo, output cnt_hi, input busy, input phase_hi, input done);
    modport gen(input start, input is_read, input cnt_lo, input cnt_hi, output busy, output phase_hi, output done);
endinterface : nand_strobe_if
`default_nettype wire

// [src/nand_strobe_gen.sv]
`default_nettype none
// Makes one low pulse then one high recovery phase, each at least the given number of cycles.
module nand_strobe_gen (
    input wire logic i_mclk,
    input wire logic i_rst,
    nand_strobe_if.gen s
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [1:0] ph_q;
    logic [1:0] ph_d;
    logic [7:0] hi_q;
    logic [7:0] hi_d;
    wire logic cnt_zero = (cnt_q == 8'h00);
    assign ph_d = (ph_q == 2'h0) ? (s.start ? 2'h1 : 2'h0) :
                  (!cnt_zero) ? ph_q : ((ph_q == 2'h1) ? 2'h2 : 2'h0);
    assign cnt_d = (ph_q == 2'h0) ? (s.start ? s.cnt_lo : 8'h00) :
                   (!cnt_zero) ? cnt_q - 8'h01 : ((ph_q == 2'h1) ? hi_q : 8'h00);
    assign hi_d = (ph_q == 2'h0 && s.start) ? s.cnt_hi : hi_q;
    assign s.busy = (ph_q != 2'h0);
    assign s.phase_hi = (ph_q == 2'h2);
    assign s.done = (ph_q == 2'h2) && cnt_zero;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ph_q <= 2'h0;
            cnt_q <= 8'h00;
            hi_q <= 8'h00;
        end else begin
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            hi_q <= hi_d;
        end
    end
endmodule : nand_strobe_gen
`default_nettype wire

// [testbench/nand_dev_model.sv]
`default_nettype none
// Behavioural flash device with its own busy timing and both output hold modes.
module nand_dev_model #(
    parameter int T_READ_NS = 300,
    parameter int T_PROG_NS = 400,
    parameter int T_GAP_NS = 100,
    parameter int T_RST_NS = 40,
    parameter int T_SLOW_NS = 2000,
    parameter int T_ACC_NS = 20
) (
    input wire logic i_cs_n,
    input wire logic i_cle,
    input wire logic i_ale,
    input wire logic i_write_strobe_n,
    input wire logic i_read_strobe_n,
    input wire logic i_write_protect_n,
    input wire logic [7:0] i_io,
    input wire logic i_ext_mode,
    input wire logic i_slow,
    output logic [7:0] o_io,
    output logic o_ready_busy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cmd_q = 8'h00;
    logic [7:0] addr_q = 8'h00;
    logic [7:0] data_q = 8'h00;
    logic [7:0] col_q = 8'h00;
    logic [7:0] dout_q = 8'h00;
    logic drive_q = 1'b0;
    int prog_cnt = 0;
    int viol_cnt = 0;
    wire standby;
    initial o_ready_busy_n = 1'b1;
    assign standby = i_cs_n && o_ready_busy_n;
    // A released bus shows the inverse of the last byte, so stale samples never pass.
    assign o_io = drive_q ? dout_q : ~dout_q;
    task automatic go_busy(input int dur);
        o_ready_busy_n <= 1'b0;
        o_ready_busy_n <= #(dur) 1'b1;
    endtask : go_busy
    always @(posedge i_write_strobe_n) begin
        if (!i_cs_n) begin
            if (!o_ready_busy_n && !(i_cle && (i_io == 8'hff || i_io == 8'h70 || i_io == 8'h71))) begin
                viol_cnt <= viol_cnt + 1;
            end else if (i_cle) begin
                cmd_q <= i_io;
                case (i_io)
                    8'h30: go_busy(i_slow ? T_SLOW_NS : T_READ_NS);
                    8'h11: go_busy(T_GAP_NS);
                    8'hff: go_busy(T_RST_NS);
                    8'h7a: col_q <= 8'h00;
                    8'h10: begin
                        if (i_write_protect_n) begin
                            prog_cnt <= prog_cnt + 1;
                            go_busy(T_PROG_NS);
                        end
                    end
                    default: ;
                endcase
            end else if (i_ale) begin
                addr_q <= i_io;
                col_q <= i_io;
            end else begin
                data_q <= i_io;
            end
        end
    end
    always @(negedge i_read_strobe_n) begin
        if (!i_cs_n) begin
            if (!o_ready_busy_n) begin
                viol_cnt <= viol_cnt + 1;
            end
            drive_q <= 1'b1;
            dout_q <= #(T_ACC_NS) col_q + 8'h40;
            col_q <= col_q + 8'h01;
        end
    end
    always @(posedge i_read_strobe_n) begin
        if (!i_ext_mode) begin
            drive_q <= 1'b0;
        end
    end
    always @(posedge i_cle or posedge i_ale or posedge i_cs_n or negedge i_write_strobe_n) begin
        drive_q <= 1'b0;
    end
endmodule : nand_dev_model
`default_nettype wire

// [testbench/testbench.sv]
`default_nettype none
`define CHECK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import nand_host_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, op_valid = 1'b0, op_last = 1'b0, op_expect_busy = 1'b0;
    logic op_release = 1'b0, wp_enable = 1'b0, ext_mode = 1'b0, slow = 1'b0;
    op_kind_t op_kind = OP_CMD;
    logic [7:0] op_data = 8'h00, io_dev, bus, rd_data, io_out, col, d, e;
    logic op_ready, rd_valid, timeout, cs_n, cle, ale, ws_n, rs_n, wp_n, io_oe, rb_n;
    int errors = 0, compares = 0, to_cnt = 0, busy_seen = 0, b0, seed = 84396;
    logic [7:0] exp_q[$];
    always #4 mclk = ~mclk;
    assign bus = io_oe ? io_out : io_dev;
    nand_host #(.RST_WAIT_CYC(8), .BUSY_TIMEOUT_CYC(64)) nand_host_i (
        .i_mclk(mclk), .i_rst(rst), .i_op_valid(op_valid), .i_op_kind(op_kind), .i_op_data(op_data),
        .i_op_last(op_last), .i_op_expect_busy(op_expect_busy), .i_op_release(op_release),
        .i_wp_enable(wp_enable), .i_io_in(bus), .i_ready_busy_n(rb_n), .o_op_ready(op_ready),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_timeout(timeout), .o_cs_n(cs_n), .o_cle(cle),
        .o_ale(ale), .o_write_strobe_n(ws_n), .o_read_strobe_n(rs_n), .o_write_protect_n(wp_n),
        .o_io_out(io_out), .o_io_oe(io_oe));
    nand_dev_model nand_dev_model_i (
        .i_cs_n(cs_n), .i_cle(cle), .i_ale(ale), .i_write_strobe_n(ws_n), .i_read_strobe_n(rs_n),
        .i_write_protect_n(wp_n), .i_io(bus), .i_ext_mode(ext_mode), .i_slow(slow), .o_io(io_dev),
        .o_ready_busy_n(rb_n));
    task automatic end_sim();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    task automatic wait_ready(input int lim);
        int n;
        n = 0;
        while (op_ready !== 1'b1) begin
            @(negedge mclk);
            n++;
            if (n > lim) begin
                errors++;
                $display("mismatch op_ready expected 1 seen %b", op_ready);
                end_sim();
            end
        end
    endtask : wait_ready
    task automatic op(input op_kind_t k, input logic [7:0] v, input logic b);
        @(negedge mclk);
        wait_ready(100);
        op_valid = 1'b1;
        op_kind = k;
        op_data = v;
        op_expect_busy = b;
        @(negedge mclk);
        op_valid = 1'b0;
        wait_ready(4000);
    endtask : op
    // Expected read bytes are queued by the driver and retired whenever the host flags a read byte.
    always @(posedge mclk) begin
        if (timeout === 1'b1) begin
            to_cnt++;
        end
        if (rb_n === 1'b0) begin
            busy_seen++;
        end
        if (rd_valid === 1'b1) begin
            `CHECK("rd_pending", 1'b1, exp_q.size() > 0)
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                `CHECK("rd_data", e, rd_data)
            end
        end
    end
    always @(negedge mclk) begin
        if (!rst) begin
            `CHECK("bus_clash", 1'b0, io_oe & nand_dev_model_i.drive_q)
        end
    end
    initial begin
        repeat (12) @(negedge mclk);
        `CHECK("rst_cs_n", 1'b1, cs_n)
        `CHECK("rst_oe", 1'b0, io_oe)
        rst = 1'b0;
        for (int m = 0; m < 2; m++) begin
            ext_mode = m[0];
            op(OP_CMD, 8'h00, 1'b0);
            `CHECK("cmd", 8'h00, nand_dev_model_i.cmd_q)
            col = 8'($random(seed));
            op(OP_ADDR, col, 1'b0);
            `CHECK("addr", col, nand_dev_model_i.addr_q)
            b0 = busy_seen;
            op(OP_CMD, 8'h30, 1'b1);
            `CHECK("read_busy", 1'b1, busy_seen > b0)
            for (int k = 0; k < 4; k++) begin
                exp_q.push_back(col + 8'(k) + 8'h40);
                op(OP_READ, 8'h00, 1'b0);
            end
            d = col + 8'h43;
            `CHECK("hold_bus", m[0] ? d : ~d, io_dev)
        end
        op(OP_CMD, 8'h7a, 1'b0);
        for (int k = 0; k < 8; k++) begin
            exp_q.push_back(8'h40 + 8'(k));
            op(OP_READ, 8'h00, 1'b0);
        end
        for (int w = 1; w >= 0; w--) begin
            wp_enable = w[0];
            op(OP_CMD, 8'h80, 1'b0);
            op(OP_ADDR, 8'($random(seed)), 1'b0);
            d = 8'($random(seed));
            op(OP_WRITE, d, 1'b0);
            `CHECK("wr_data", d, nand_dev_model_i.data_q)
            `CHECK("wp_pin", w[0], wp_n)
            op(OP_CMD, 8'h10, 1'b1);
            `CHECK("prog_cnt", 1, nand_dev_model_i.prog_cnt)
        end
        for (int i = 0; i < 2; i++) begin
            b0 = busy_seen;
            op(OP_CMD, i == 0 ? 8'h11 : 8'hff, 1'b1);
            `CHECK("short_busy", 1'b1, busy_seen > b0)
        end
        slow = 1'b1;
        op(OP_CMD, 8'h30, 1'b1);
        `CHECK("timeout", 1, to_cnt)
        slow = 1'b0;
        for (int n = 0; n < 400 && rb_n !== 1'b1; n++) @(negedge mclk);
        `CHECK("ready", 1'b1, rb_n)
        op_release = 1'b1;
        for (int n = 0; n < 20 && cs_n !== 1'b1; n++) @(negedge mclk);
        `CHECK("standby", 1'b1, nand_dev_model_i.standby)
        op_release = 1'b0;
        `CHECK("strobe_in_busy", 0, nand_dev_model_i.viol_cnt)
        `CHECK("queue_left", 0, exp_q.size())
        end_sim();
    end
endmodule : testbench
`default_nettype wire
